// ### hw/sdpi_pkg.sv
// Shared constants and types for the synchronous DRAM pin interface
package sdpi_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 11;
  localparam int BANK_W = 2;
  localparam int MASK_W = 4;
  localparam int LANE_W = 8;
  localparam int COL_W = 8;
  localparam int ROW_W = 11;
  localparam int ROWS = 2048;
  localparam int COLS = 256;
  localparam int BANKS = 4;
  localparam int MEM_DEPTH = 1024;
  localparam int MEM_AW = 10;
  localparam int AP_BIT = 10;
  localparam int BURST_LEN = 4;
  localparam int CAS_LAT = 2;
  localparam int MASK_LAT = 2;
  localparam int FIFO_DEPTH = 8;
  localparam logic [2:0] BURST_LAST = 3'h3;
  localparam logic [2:0] CL_LAST = 3'h1;
  localparam logic [2:0] MASK_PIPE_LAST = 3'h1;
  // Data-state count one cycle before the first read beat reaches the synchroniser output
  localparam logic [2:0] CAP_START = 3'h5;
  localparam logic [10:0] MODE_DEFAULT = 11'h022;

  // Command code on {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SDPI_CMD_MRS = 4'h0,
    SDPI_CMD_REF = 4'h1,
    SDPI_CMD_PRE = 4'h2,
    SDPI_CMD_ACT = 4'h3,
    SDPI_CMD_WR = 4'h4,
    SDPI_CMD_RD = 4'h5,
    SDPI_CMD_BST = 4'h6,
    SDPI_CMD_NOP = 4'h7,
    SDPI_CMD_INH = 4'h8
  } sdpi_cmd_t;

  // Controller-side user register map (AHB-Lite byte offsets)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam int CTRL_GO = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_CKE = 2;
  localparam int CTRL_MRS = 3;
  localparam int CTRL_PDN = 4;
endpackage

// ### hw/sdpi_if.sv
// Pin-level carrier between controller and DRAM
`timescale 1ns/1ps
interface sdpi_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] ba;
  logic [10:0] addr;
  logic [3:0] dqm;
  logic [31:0] dq_ctl_o;
  logic dq_ctl_oe;
  logic [31:0] dq_mem_o;
  logic [3:0] dq_mem_oe;
  logic [31:0] dq;

  // Resolved bus level per byte lane
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dq_mem_oe[i]) begin
        dq[i*8 +: 8] = dq_mem_o[i*8 +: 8];
      end else if (dq_ctl_oe) begin
        dq[i*8 +: 8] = dq_ctl_o[i*8 +: 8];
      end else begin
        dq[i*8 +: 8] = 8'h00;
      end
    end
  end

  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl_o, dq_ctl_oe,
               input dq);
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
               output dq_mem_o, dq_mem_oe);
endinterface

// ### hw/sdpi_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module sdpi_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;
  logic full;
  logic empty;

  // Pointer flags
  assign empty = (wp == rp);
  assign full = (wp[AW-1:0] == rp[AW-1:0]) && (wp[AW] != rp[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp[AW-1:0]];

  // Storage write
  always_ff @(posedge hclk) begin
    if (in_valid && !full) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (in_valid && !full) begin
        wp <= wp + 1'b1;
      end
      if (out_ready && !empty) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule

// ### hw/sdpi_mem.sv
// DRAM end: samples pins on the clock, decodes commands and moves burst data
//
// Overview of operation
// RL1 - Every input pin captured on rising edge
// RL2 - Burst column counter advances each active edge
// RL3 - Clock enable low freezes internal clock use
// RL4 - Clock enable asynchronous while powered down
// RL5 - Powered down: ignore all inputs except enable
// RL6 - Chip select high masks new commands
// RL7 - Running burst continues while deselected, masks work
// RL8 - Command decoded from select and three strobes
// RL9 - Write mask high leaves stored byte unchanged
// RL10 - Read mask high floats lane two clocks later
// RL11 - Mask n controls data byte lane n
// RL12 - Activate takes address 10..0 as row
// RL13 - Read/write column 7..0; bit 10 autoprecharge
// RL14 - Precharge bit 10 all, else selected bank
// RL15 - Mode load takes opcode from address
// RL16 - Controller may tie clock enable high
// RL17 - Activate bank inputs pick target bank
// RL18 - Data bus driven by one side only
`timescale 1ns/1ps
module sdpi_mem (
  input wire logic hclk,
  input wire logic hresetn,
  sdpi_if.mem pins,
  output logic [3:0] bank_open,
  output logic power_down,
  output logic [10:0] mode_word
);
  typedef enum logic [1:0] {
    SDPI_M_IDLE = 2'b00,
    SDPI_M_RD = 2'b01,
    SDPI_M_WR = 2'b10
  } sdpi_mstate_t;

  typedef struct packed {
    sdpi_mstate_t st;
    logic [3:0] bank_open;
    logic [43:0] rows;
    logic [1:0] bank;
    logic [7:0] col;
    logic [2:0] beat;
    logic ap;
    logic pdn;
    logic [10:0] mode;
    logic [2:0] cl;
    logic rd_pend;
    logic [31:0] rd_word;
    logic [3:0] rd_lane;
    logic [7:0] mq1;
    logic [31:0] dq_o;
    logic [3:0] dq_oe;
  } sdpi_mem_t;

  sdpi_mem_t r;
  sdpi_mem_t next_r;
  logic [31:0] array [sdpi_pkg::MEM_DEPTH];
  logic cke_q;
  logic cs_q;
  logic ras_q;
  logic cas_q;
  logic we_q;
  logic [1:0] ba_q;
  logic [10:0] a_q;
  logic [3:0] dqm_q;
  logic [31:0] dq_q;
  logic wr_en;
  logic [9:0] wr_idx;
  sdpi_pkg::sdpi_cmd_t cmd;

  // Row/bank/column fold into a small array index
  function automatic logic [9:0] idx(input logic [1:0] b, input logic [10:0] row,
                                     input logic [7:0] c);
    idx = {b, row[1:0] ^ c[7:6], c[5:0]};
  endfunction

  // Register every input pin on the rising edge; enable also seen async [RL1] [RL4]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cke_q <= 1'b1; // Idle level of the enable pin, so reset brings no false suspend
      cs_q <= 1'b1;
      ras_q <= 1'b1;
      cas_q <= 1'b1;
      we_q <= 1'b1;
      ba_q <= 2'h0;
      a_q <= 11'h000;
      dqm_q <= 4'hf;
      dq_q <= 32'h00000000;
    end else begin
      cke_q <= pins.cke;
      if (!r.pdn) begin // Receivers off while powered down [RL5]
        cs_q <= pins.cs_n;
        ras_q <= pins.ras_n;
        cas_q <= pins.cas_n;
        we_q <= pins.we_n;
        ba_q <= pins.ba;
        a_q <= pins.addr;
        dqm_q <= pins.dqm;
        dq_q <= pins.dq;
      end
    end
  end

  // Command from select plus strobes; deselect masks it [RL6] [RL8]
  assign cmd = cs_q ? sdpi_pkg::SDPI_CMD_INH : sdpi_pkg::sdpi_cmd_t'({1'b0, ras_q, cas_q, we_q});

  // Write strobe with per-lane mask; beat zero lands with the command [RL9] [RL11]
  assign wr_en = ((r.st == SDPI_M_WR) || (cmd == sdpi_pkg::SDPI_CMD_WR)) && cke_q && !r.pdn;
  assign wr_idx = (cmd == sdpi_pkg::SDPI_CMD_WR) ?
    idx(ba_q, r.rows[ba_q*11 +: 11], a_q[7:0]) : idx(r.bank, r.rows[r.bank*11 +: 11], r.col);

  always_ff @(posedge hclk) begin
    for (int i = 0; i < 4; i++) begin
      if (wr_en && !dqm_q[i]) begin // [RL9] [RL11]
        array[wr_idx][i*8 +: 8] <= dq_q[i*8 +: 8];
      end
    end
  end

  // Next-state logic
  always_comb begin
    next_r = r;
    // Leave power-down on enable alone, asynchronously sampled [RL4] [RL5]
    if (r.pdn) begin
      if (pins.cke) begin
        next_r.pdn = 1'b0;
      end
    end else if (!cke_q) begin
      // Clock suspended: hold all state; power-down if no burst [RL3]
      if (r.st == SDPI_M_IDLE) begin
        next_r.pdn = 1'b1;
      end
    end else begin
      // Output mask pipeline: lane floats two clocks after mask [RL10]
      next_r.mq1 = {r.mq1[3:0], dqm_q};
      next_r.rd_lane = r.mq1[7:4];
      // Read data pipeline: beat driven three clocks after the command is sampled
      next_r.rd_pend = 1'b0;
      if (r.rd_pend) begin
        next_r.dq_o = r.rd_word;
        next_r.dq_oe = ~r.mq1[3:0]; // [RL10] [RL18]
      end else begin
        next_r.dq_oe = 4'h0; // [RL18]
      end
      // Burst continues regardless of chip select [RL2] [RL7]
      if (r.st != SDPI_M_IDLE) begin
        if (r.st == SDPI_M_RD) begin
          next_r.rd_word = array[idx(r.bank, r.rows[r.bank*11 +: 11], r.col)];
          next_r.rd_pend = 1'b1;
        end
        next_r.col = r.col + 8'h01; // [RL2]
        next_r.beat = r.beat + 3'h1;
        if (r.beat == sdpi_pkg::BURST_LAST) begin
          next_r.st = SDPI_M_IDLE;
          if (r.ap) begin
            next_r.bank_open[r.bank] = 1'b0; // [RL13]
          end
        end
      end
      unique case (cmd)
        sdpi_pkg::SDPI_CMD_ACT: begin
          next_r.bank_open[ba_q] = 1'b1; // [RL17]
          next_r.rows[ba_q*11 +: 11] = a_q; // [RL12]
        end
        sdpi_pkg::SDPI_CMD_RD, sdpi_pkg::SDPI_CMD_WR: begin
          next_r.st = (cmd == sdpi_pkg::SDPI_CMD_RD) ? SDPI_M_RD : SDPI_M_WR;
          next_r.bank = ba_q;
          next_r.col = a_q[7:0]; // [RL13]
          next_r.ap = a_q[sdpi_pkg::AP_BIT]; // [RL13]
          next_r.beat = 3'h0;
          if (cmd == sdpi_pkg::SDPI_CMD_WR) begin
            // Beat zero is stored with the command itself
            next_r.col = a_q[7:0] + 8'h01;
            next_r.beat = 3'h1;
          end
        end
        sdpi_pkg::SDPI_CMD_PRE: begin
          if (a_q[sdpi_pkg::AP_BIT]) begin
            next_r.bank_open = 4'h0; // [RL14]
          end else begin
            next_r.bank_open[ba_q] = 1'b0; // [RL14]
          end
        end
        sdpi_pkg::SDPI_CMD_BST: begin
          next_r.st = SDPI_M_IDLE;
        end
        sdpi_pkg::SDPI_CMD_MRS: begin
          next_r.mode = a_q; // [RL15]
        end
        default: begin
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.mode <= sdpi_pkg::MODE_DEFAULT;
      r.mq1 <= 8'hff;
    end else begin
      r <= next_r;
    end
  end

  assign pins.dq_mem_o = r.dq_o;
  assign pins.dq_mem_oe = r.dq_oe;
  assign bank_open = r.bank_open;
  assign power_down = r.pdn;
  assign mode_word = r.mode;
endmodule

// ### hw/sdpi_ctl.sv
// Controller end: AHB-Lite registers, command sequencing, read data FIFO
`timescale 1ns/1ps
module sdpi_ctl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  sdpi_if.ctl pins
);
  typedef enum logic [2:0] {
    SDPI_C_IDLE = 3'b000,
    SDPI_C_ACT = 3'b001,
    SDPI_C_CMD = 3'b010,
    SDPI_C_DATA = 3'b011,
    SDPI_C_PRE = 3'b100
  } sdpi_cstate_t;

  typedef struct packed {
    sdpi_cstate_t st;
    logic [4:0] ctrl;
    logic [20:0] addr;
    logic [31:0] wdata;
    logic [3:0] mask;
    logic [2:0] cnt;
    logic busy;
    logic dph;
    logic dwr;
    logic [7:0] daddr;
    logic [31:0] hrdata;
    logic cke;
    logic [3:0] pcmd;
    logic [1:0] ba;
    logic [10:0] a;
    logic [3:0] dqm;
    logic [31:0] dqo;
    logic dqoe;
  } sdpi_ctl_t;

  sdpi_ctl_t r;
  sdpi_ctl_t next_r;
  logic [31:0] dq_s1;
  logic [31:0] dq_s2;
  logic f_in_valid;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [31:0] f_out_data;
  logic [2:0] cap_cnt;

  // Pin bus crosses two flip-flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dq_s1 <= 32'h00000000;
      dq_s2 <= 32'h00000000;
    end else begin
      dq_s1 <= pins.dq;
      dq_s2 <= dq_s1;
    end
  end

  sdpi_fifo #(.WIDTH(32), .DEPTH(sdpi_pkg::FIFO_DEPTH)) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(dq_s2),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // Read beats arrive at fixed delay; capture counter follows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_cnt <= 3'h0;
    end else if (r.st == SDPI_C_DATA && !r.ctrl[sdpi_pkg::CTRL_WRITE] &&
                 r.cnt == sdpi_pkg::CAP_START) begin
      cap_cnt <= 3'(sdpi_pkg::BURST_LEN);
    end else if (cap_cnt != 3'h0) begin
      cap_cnt <= cap_cnt - 3'h1;
    end
  end
  // One push per beat while the four beats stand at the synchroniser output
  assign f_in_valid = (cap_cnt != 3'h0);
  assign f_out_ready = r.dph && !r.dwr && (r.daddr == sdpi_pkg::REG_RDATA);

  // Next-state logic
  always_comb begin
    next_r = r;
    next_r.hrdata = 32'h00000000;
    // AHB data phase
    if (r.dph) begin
      next_r.dph = 1'b0;
      if (r.dwr) begin
        unique case (r.daddr)
          sdpi_pkg::REG_CTRL: next_r.ctrl = hwdata[4:0];
          sdpi_pkg::REG_ADDR: next_r.addr = hwdata[20:0];
          sdpi_pkg::REG_WDATA: next_r.wdata = hwdata;
          sdpi_pkg::REG_MASK: next_r.mask = hwdata[3:0];
          default: begin
          end
        endcase
      end
    end
    if (hsel && hready && htrans[1]) begin
      next_r.dph = 1'b1;
      next_r.dwr = hwrite;
      next_r.daddr = haddr[7:0];
      unique case (haddr[7:0])
        sdpi_pkg::REG_CTRL: next_r.hrdata = {27'h0, r.ctrl};
        sdpi_pkg::REG_ADDR: next_r.hrdata = {11'h0, r.addr};
        sdpi_pkg::REG_WDATA: next_r.hrdata = r.wdata;
        sdpi_pkg::REG_RDATA: next_r.hrdata = f_out_data;
        sdpi_pkg::REG_STATUS: next_r.hrdata = {27'h0, f_out_valid, !f_in_ready, r.st[1:0], r.busy};
        sdpi_pkg::REG_MASK: next_r.hrdata = {28'h0, r.mask};
        default: next_r.hrdata = 32'h00000000;
      endcase
    end
    // Pin defaults: deselected, so bursts run on with select high [RL7] [RL8]
    next_r.pcmd = sdpi_pkg::SDPI_CMD_INH;
    next_r.dqoe = 1'b0; // [RL18]
    // Enable held high unless software requests power-down [RL16]
    next_r.cke = !r.ctrl[sdpi_pkg::CTRL_PDN];
    next_r.cnt = r.cnt + 3'h1;
    unique case (r.st)
      SDPI_C_IDLE: begin
        next_r.busy = 1'b0;
        if (r.ctrl[sdpi_pkg::CTRL_GO] && !r.busy && r.cke && f_in_ready) begin
          next_r.ctrl[sdpi_pkg::CTRL_GO] = 1'b0;
          next_r.busy = 1'b1;
          next_r.cnt = 3'h0;
          if (r.ctrl[sdpi_pkg::CTRL_MRS]) begin
            next_r.pcmd = sdpi_pkg::SDPI_CMD_MRS;
            next_r.a = r.addr[10:0]; // [RL15]
          end else begin
            next_r.pcmd = sdpi_pkg::SDPI_CMD_ACT;
            next_r.ba = r.addr[20:19]; // [RL17]
            next_r.a = r.addr[18:8]; // [RL12]
            next_r.st = SDPI_C_ACT;
          end
        end
      end
      SDPI_C_ACT: begin
        if (r.cnt == 3'h1) begin
          next_r.pcmd = r.ctrl[sdpi_pkg::CTRL_WRITE] ? sdpi_pkg::SDPI_CMD_WR : sdpi_pkg::SDPI_CMD_RD;
          next_r.a = {1'b1, 2'h0, r.addr[7:0]}; // Auto precharge [RL13]
          next_r.dqm = r.mask; // [RL9] [RL10] [RL11]
          next_r.cnt = 3'h0;
          next_r.st = SDPI_C_DATA;
          if (r.ctrl[sdpi_pkg::CTRL_WRITE]) begin
            next_r.dqo = r.wdata;
            next_r.dqoe = 1'b1; // [RL18]
          end
        end
      end
      SDPI_C_DATA: begin
        if (r.ctrl[sdpi_pkg::CTRL_WRITE] && r.cnt < sdpi_pkg::BURST_LAST) begin
          next_r.dqo = r.wdata + {29'h0, r.cnt} + 32'h1;
          next_r.dqoe = 1'b1;
        end
        if (r.cnt == 3'h7) begin
          next_r.st = SDPI_C_PRE;
        end
      end
      SDPI_C_PRE: begin
        next_r.pcmd = sdpi_pkg::SDPI_CMD_PRE;
        next_r.a = 11'h400; // All banks [RL14]
        next_r.dqm = 4'hf;
        next_r.st = SDPI_C_IDLE;
      end
      default: next_r.st = SDPI_C_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.pcmd <= sdpi_pkg::SDPI_CMD_INH;
      r.dqm <= 4'hf;
      r.cke <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pins.cke = r.cke;
  assign pins.cs_n = r.pcmd[3];
  assign pins.ras_n = r.pcmd[2];
  assign pins.cas_n = r.pcmd[1];
  assign pins.we_n = r.pcmd[0];
  assign pins.ba = r.ba;
  assign pins.addr = r.a;
  assign pins.dqm = r.dqm;
  assign pins.dq_ctl_o = r.dqo;
  assign pins.dq_ctl_oe = r.dqoe;
endmodule

// ### testbench/sdpi_chk_sva.sv
// Concurrent checks on the pin carrier between controller and DRAM end
`timescale 1ns/1ps
module sdpi_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [10:0] addr,
  input wire logic [3:0] dqm,
  input wire logic dq_ctl_oe,
  input wire logic [3:0] dq_mem_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [3:0] cmd;
  logic rd;
  logic wr;
  // Command code straight from the four pins, with no select masking as at the DRAM end
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign rd = (cmd == sdpi_pkg::SDPI_CMD_RD);
  assign wr = (cmd == sdpi_pkg::SDPI_CMD_WR);

  AST_ONE_DRIVER: assert property (!(dq_ctl_oe && (|dq_mem_oe)))
    else $error("both ends drive the data bus");
  AST_RD_FLOAT: assert property ((cke && $past(cke) && $past(cke, 2) && $past(cke, 3)) |->
    ((dq_mem_oe & $past(dqm, 3)) == 4'h0))
    else $error("masked read lane still driven");
  AST_RD_LAT: assert property ((rd && dqm != 4'hf) |-> ##[1:4] (|dq_mem_oe))
    else $error("read data never driven");
  AST_RD_SRC: assert property ($rose(|dq_mem_oe) |->
    ($past(rd, 2) || $past(rd, 3) || $past(rd, 4)))
    else $error("data driven without a read command");
  AST_PDN_QUIET: assert property ((!cke && $past(cke) == 1'b0) |-> dq_mem_oe == 4'h0)
    else $error("data driven while powered down");
  AST_ACT_RW: assert property ((rd || wr) |-> $past(cmd, 2) == sdpi_pkg::SDPI_CMD_ACT)
    else $error("access without activate two cycles before");
  AST_AP_BIT: assert property ((rd || wr) |-> addr[sdpi_pkg::AP_BIT])
    else $error("auto precharge bit low on access");
  AST_WR_BURST: assert property (wr |-> dq_ctl_oe [*4])
    else $error("write burst not driven for four beats");

  // Main traffic kinds
  COV_RD: cover property (rd);
  COV_WR: cover property (wr);
  COV_MRS: cover property (cmd == sdpi_pkg::SDPI_CMD_MRS);
  COV_PDN: cover property (!cke);
endmodule

// ### testbench/test_sdram_pin_command_interface.sv
// Self-checking bench: AHB-Lite driven controller facing the DRAM end
`timescale 1ns/1ps
module test_sdram_pin_command_interface;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [3:0] bank_open;
  logic power_down;
  logic [10:0] mode_word;
  int err_total = 0;
  int comparisons = 0;
  logic [31:0] rv;
  logic [31:0] exp_w [4];

  sdpi_if pins ();
  // Clock of 100 ns period
  always #50 hclk = ~hclk;

  sdpi_ctl u_sdpi_ctl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .pins(pins.ctl));
  sdpi_mem u_sdpi_mem (.hclk(hclk), .hresetn(hresetn), .pins(pins.mem),
    .bank_open(bank_open), .power_down(power_down), .mode_word(mode_word));
  sdpi_chk u_sdpi_chk (.hclk(hclk), .hresetn(hresetn), .cke(pins.cke), .cs_n(pins.cs_n),
    .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n), .addr(pins.addr),
    .dqm(pins.dqm), .dq_ctl_oe(pins.dq_ctl_oe), .dq_mem_oe(pins.dq_mem_oe));

  // Verdict and end of run
  task automatic wrap_up();
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        err_total++;
        wrap_up();
      end
      @(posedge hclk);
    end
  endtask

  // One single AHB-Lite word transfer
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    ahb(1'b1, a, d, dummy);
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask

  // Poll until the start bit cleared and the controller is idle
  task automatic wait_idle();
    logic [31:0] c;
    logic [31:0] s;
    int n;
    for (n = 0; n < 200; n++) begin
      rreg(sdpi_pkg::REG_CTRL, c);
      rreg(sdpi_pkg::REG_STATUS, s);
      if (c[0] === 1'b0 && s[0] === 1'b0) begin
        break;
      end
    end
    if (n >= 200) begin
      err_total++;
      wrap_up();
    end
  endtask

  // Burst access to row 0x123 of a bank
  task automatic access(input logic wr, input logic [1:0] b, input logic [3:0] m,
                        input logic [31:0] wd);
    wreg(sdpi_pkg::REG_ADDR, {11'h0, b, 11'h123, 8'h10});
    wreg(sdpi_pkg::REG_MASK, {28'h0, m});
    wreg(sdpi_pkg::REG_WDATA, wd);
    wreg(sdpi_pkg::REG_CTRL, {30'h0, wr, 1'b1});
    wait_idle();
  endtask

  function automatic logic [31:0] lanes(input logic [3:0] m);
    for (int i = 0; i < 4; i++) begin
      lanes[i*8 +: 8] = {8{m[i]}};
    end
  endfunction

  // Pop four read beats; floated lanes read as zero
  task automatic pop_chk(input logic [3:0] m);
    for (int i = 0; i < 4; i++) begin
      rreg(sdpi_pkg::REG_RDATA, rv);
      chk_word(rv, exp_w[i] & ~lanes(m));
    end
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_word({21'h0, mode_word}, {21'h0, sdpi_pkg::MODE_DEFAULT});
    chk_word({28'h0, bank_open}, 32'h0);
    chk_flag(power_down, 1'b0);
    chk_flag(pins.cke, 1'b1);
    rreg(8'h20, rv);
    chk_word(rv, 32'h0);
    wreg(sdpi_pkg::REG_ADDR, 32'h5a5);
    wreg(sdpi_pkg::REG_CTRL, 32'h9);
    wait_idle();
    chk_word({21'h0, mode_word}, 32'h5a5);
    access(1'b1, 2'h2, 4'h0, 32'h11223300);
    chk_word({28'h0, bank_open}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      exp_w[i] = 32'h11223300 + i;
    end
    access(1'b0, 2'h2, 4'h0, 32'h0);
    pop_chk(4'h0);
    access(1'b1, 2'h1, 4'h0, 32'h55667700);
    access(1'b0, 2'h2, 4'h0, 32'h0);
    pop_chk(4'h0);
    access(1'b1, 2'h2, 4'h5, 32'haabbcc00);
    for (int i = 0; i < 4; i++) begin
      exp_w[i] = (exp_w[i] & lanes(4'h5)) | ((32'haabbcc00 + i) & ~lanes(4'h5));
    end
    access(1'b0, 2'h2, 4'h0, 32'h0);
    pop_chk(4'h0);
    access(1'b0, 2'h2, 4'h2, 32'h0);
    pop_chk(4'h2);
    access(1'b0, 2'h2, 4'h0, 32'h0);
    access(1'b0, 2'h2, 4'h0, 32'h0);
    rreg(sdpi_pkg::REG_STATUS, rv);
    chk_flag(rv[3], 1'b1);
    pop_chk(4'h0);
    pop_chk(4'h0);
    rreg(sdpi_pkg::REG_STATUS, rv);
    chk_flag(rv[4], 1'b0);
    wreg(sdpi_pkg::REG_CTRL, 32'h10);
    rreg(sdpi_pkg::REG_STATUS, rv);
    rreg(sdpi_pkg::REG_STATUS, rv);
    chk_flag(pins.cke, 1'b0);
    chk_flag(power_down, 1'b1);
    wreg(sdpi_pkg::REG_CTRL, 32'h0);
    rreg(sdpi_pkg::REG_STATUS, rv);
    rreg(sdpi_pkg::REG_STATUS, rv);
    chk_flag(power_down, 1'b0);
    access(1'b0, 2'h2, 4'h0, 32'h0);
    pop_chk(4'h0);
    chk_word({21'h0, mode_word}, 32'h5a5);
    wrap_up();
  end
endmodule
